// *** dv/bridge_side_model.sv ***
`timescale 1ns/1ps
module bridge_side_model (
    input wire logic [3:0] pin_val,
    input wire logic [3:0] pin_oe_n,
    input wire logic [2:0] cause,
    output logic comp_1,
    output logic comp_2,
    output logic fault_n,
    output logic [3:0] level
);
    // undriven pins fall to the pull-downs that keep the switches off
    assign level = pin_val & ~pin_oe_n;
    // fault line idles high through its pull-up, low means fault
    assign fault_n = ~cause[2];
    assign comp_1 = cause[0];
    assign comp_2 = cause[1];
endmodule // bridge_side_model

// *** dv/tb_top.sv ***
`timescale 1ns/1ps
module tb_top
    import pwm_shutdown_pkg::*;
;
    logic clock, rst_n, pwm_period_start, comparator_1, comparator_2, fault_input_n, irq;
    logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb, pwm_raw, output_oe_n, level;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic output_a, output_b, output_c, output_d;
    logic [2:0] cause;
    logic [7:0] rdat;
    int num_errors, n_compared;

    pwm_auto_shutdown_restart u_dut (.clock, .rst_n, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .pwm_period_start, .pwm_raw, .comparator_1, .comparator_2, .fault_input_n,
        .output_a, .output_b, .output_c, .output_d, .output_oe_n, .irq);

    bridge_side_model u_bridge (.pin_val({output_d, output_c, output_b, output_a}),
        .pin_oe_n(output_oe_n), .cause(cause), .comp_1(comparator_1),
        .comp_2(comparator_2), .fault_n(fault_input_n), .level(level));

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    task automatic summarize();
        $display("compared %0d errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic stuck();
        num_errors++;
        $display("BAD handshake expected answer seen none");
        summarize();
    endtask

    // each task starts one edge later so a strobe is never dropped and raised in one step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        int n;
        logic ta, tw, got;
        got = 1'b0;
        @(posedge clock);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 40 && !got; n++) begin
            @(negedge clock);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            got = s_axi_bvalid;
            resp = s_axi_bresp;
            @(posedge clock);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            if (got) s_axi_bready <= 1'b0;
        end
        if (!got) stuck();
    endtask

    task automatic rd(input logic [7:0] a);
        int n;
        logic ta, got;
        got = 1'b0;
        @(posedge clock);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 40 && !got; n++) begin
            @(negedge clock);
            ta = s_axi_arvalid && s_axi_arready;
            got = s_axi_rvalid;
            rdat = s_axi_rdata[7:0];
            resp = s_axi_rresp;
            @(posedge clock);
            if (ta) s_axi_arvalid <= 1'b0;
            if (got) s_axi_rready <= 1'b0;
        end
        if (!got) stuck();
    endtask

    task automatic tick();
        @(posedge clock);
        pwm_period_start <= 1'b1;
        @(posedge clock);
        pwm_period_start <= 1'b0;
        repeat (2) @(posedge clock);
    endtask

    // pins reach the safe state one edge after the cause is sampled
    task automatic set_cause(input logic [2:0] c);
        @(posedge clock);
        cause <= c;
        repeat (3) @(posedge clock);
    endtask

    task automatic pins(input logic [3:0] e);
        chk("pins", {4'h0, e}, {4'h0, level});
    endtask

    initial begin
        logic [2:0] sel;
        int i, k;
        rst_n = 1'b0;
        s_axi_awaddr = '0;
        s_axi_araddr = '0;
        s_axi_awvalid = 1'b0;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hF;
        pwm_period_start = 1'b0;
        pwm_raw = 4'h3;
        cause = 3'h0;
        repeat (4) @(posedge clock);
        rst_n <= 1'b1;
        for (i = 0; i < 6; i++) begin
            rd(8'(i * 4));
            chk("reset value", 8'h00, rdat);
            chk("read resp", {6'h0, AXI_OKAY}, {6'h0, resp});
        end
        chk("pin enables", 8'h0F, {4'h0, output_oe_n});
        rd(8'h20);
        chk("unmapped read", {6'h0, AXI_SLVERR}, {6'h0, resp});
        wr(8'h20, 8'hFF);
        chk("unmapped write", {6'h0, AXI_SLVERR}, {6'h0, resp});
        wr(INT_MASK_OFS, 8'h02);
        chk("write resp", {6'h0, AXI_OKAY}, {6'h0, resp});
        s_axi_wstrb <= 4'h0;
        wr(INT_MASK_OFS, 8'h03);
        s_axi_wstrb <= 4'hF;
        rd(INT_MASK_OFS);
        chk("strobe off", 8'h02, rdat);
        wr(PWM_CONTROL_OFS, 8'h02);
        tick();
        rd(INT_STATUS_OFS);
        chk("period event", 8'h01, rdat);
        chk("masked irq", 8'h00, {7'h0, irq});
        wr(PIN_ENABLE_OFS, 8'h0F);
        tick();
        pins(4'h6);
        wr(SHUTDOWN_CONTROL_OFS, 8'h44);
        set_cause(3'h4);
        pins(4'h5);
        chk("irq", 8'h01, {7'h0, irq});
        wr(SHUTDOWN_CONTROL_OFS, 8'h44);
        rd(SHUTDOWN_CONTROL_OFS);
        chk("flag under cause", 8'hC4, rdat);
        set_cause(3'h0);
        tick();
        rd(SHUTDOWN_CONTROL_OFS);
        chk("flag no restart", 8'hC4, rdat);
        pins(4'h5);
        wr(SHUTDOWN_CONTROL_OFS, 8'h44);
        rd(SHUTDOWN_CONTROL_OFS);
        chk("flag cleared", 8'h44, rdat);
        pins(4'h5);
        tick();
        pins(4'h6);
        wr(INT_STATUS_OFS, 8'h03);
        rd(INT_STATUS_OFS);
        chk("status cleared", 8'h00, rdat);
        chk("irq cleared", 8'h00, {7'h0, irq});
        wr(DEADBAND_RESTART_OFS, 8'h80);
        wr(SHUTDOWN_CONTROL_OFS, 8'h14);
        set_cause(3'h1);
        rd(SHUTDOWN_CONTROL_OFS);
        chk("flag comparator", 8'h94, rdat);
        set_cause(3'h0);
        rd(SHUTDOWN_CONTROL_OFS);
        chk("flag auto clear", 8'h14, rdat);
        pins(4'h5);
        tick();
        pins(4'h6);
        wr(DEADBAND_RESTART_OFS, 8'h00);
        wr(SHUTDOWN_CONTROL_OFS, 8'h8B);
        repeat (3) @(posedge clock);
        chk("forced tristate", 8'h0F, {4'h0, output_oe_n});
        wr(SHUTDOWN_CONTROL_OFS, 8'h0B);
        tick();
        chk("released drive", 8'h00, {4'h0, output_oe_n});
        wr(PIN_ENABLE_OFS, 8'h00);
        wr(PWM_CONTROL_OFS, 8'h01);
        wr(PIN_ENABLE_OFS, 8'h0F);
        tick();
        pins(4'h9);
        for (i = 0; i < 8; i++) begin
            for (k = 0; k < 3; k++) begin
                sel = 3'(i);
                wr(SHUTDOWN_CONTROL_OFS, {1'b0, sel, 4'h0});
                set_cause(3'(1 << k));
                rd(SHUTDOWN_CONTROL_OFS);
                chk("source decode", {sel[k], sel, 4'h0}, rdat);
                set_cause(3'h0);
            end
        end
        summarize();
    end
endmodule // tb_top

// *** hw/pwm_auto_shutdown_restart.sv ***
`timescale 1ns/1ps
module pwm_auto_shutdown_restart
    import pwm_shutdown_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic pwm_period_start,
    input wire logic [3:0] pwm_raw,
    input wire logic comparator_1,
    input wire logic comparator_2,
    input wire logic fault_input_n,
    output logic output_a,
    output logic output_b,
    output logic output_c,
    output logic output_d,
    output logic [3:0] output_oe_n,
    output logic irq
);
    logic [7:0] ctrl_reg;
    logic auto_restart_enable;
    logic [6:0] deadband_reg;
    logic [1:0] output_polarity_select;
    logic [3:0] pin_enable_reg;
    logic [IRQ_W-1:0] status_reg, mask_reg;
    logic shut_reg, cause_prev_reg;
    logic [3:0] out_reg, oe_n_reg;
    logic irq_reg;

    logic [ADDR_W-1:0] awaddr_reg;
    logic awready_reg, wready_reg;
    logic [7:0] wdata_reg;
    logic wstrb0_reg;
    logic bvalid_reg, rvalid_reg, arready_reg;
    logic [1:0] bresp_reg, rresp_reg;
    logic [31:0] rdata_reg;

    logic wr_fire, wr_ctrl, wr_db, wr_pol, wr_pin, wr_stat, wr_mask, wr_hit;
    logic [2:0] src_sel;
    logic cause;
    logic flag_next, shut_next;
    logic [IRQ_W-1:0] event_vec;

    // ---------------- AXI4-Lite write path ----------------
    // ready lines are flops of their own so that every port leaves a register
    assign wr_fire = !awready_reg && !wready_reg && !bvalid_reg;
    assign wr_ctrl = wr_fire && wstrb0_reg && awaddr_reg == SHUTDOWN_CONTROL_OFS;
    assign wr_db = wr_fire && wstrb0_reg && awaddr_reg == DEADBAND_RESTART_OFS;
    assign wr_pol = wr_fire && wstrb0_reg && awaddr_reg == PWM_CONTROL_OFS;
    assign wr_pin = wr_fire && wstrb0_reg && awaddr_reg == PIN_ENABLE_OFS;
    assign wr_stat = wr_fire && wstrb0_reg && awaddr_reg == INT_STATUS_OFS;
    assign wr_mask = wr_fire && wstrb0_reg && awaddr_reg == INT_MASK_OFS;
    assign wr_hit = awaddr_reg == SHUTDOWN_CONTROL_OFS || awaddr_reg == DEADBAND_RESTART_OFS
        || awaddr_reg == PWM_CONTROL_OFS || awaddr_reg == PIN_ENABLE_OFS
        || awaddr_reg == INT_STATUS_OFS || awaddr_reg == INT_MASK_OFS;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            awready_reg <= 1'b1;
            awaddr_reg <= '0;
        end else if (s_axi_awvalid && awready_reg) begin
            awready_reg <= 1'b0;
            awaddr_reg <= s_axi_awaddr;
        end else if (wr_fire) begin
            awready_reg <= 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            wready_reg <= 1'b1;
            wdata_reg <= 8'h00;
            wstrb0_reg <= 1'b0;
        end else if (s_axi_wvalid && wready_reg) begin
            wready_reg <= 1'b0;
            wdata_reg <= s_axi_wdata[7:0];
            wstrb0_reg <= s_axi_wstrb[0];
        end else if (wr_fire) begin
            wready_reg <= 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= AXI_OKAY;
        end else if (wr_fire) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= wr_hit ? AXI_OKAY : AXI_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    assign s_axi_awready = awready_reg;
    assign s_axi_wready = wready_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;

    // ---------------- AXI4-Lite read path ----------------
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rvalid_reg <= 1'b0;
            arready_reg <= 1'b1;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= AXI_OKAY;
        end else if (s_axi_arvalid && arready_reg) begin
            rvalid_reg <= 1'b1;
            arready_reg <= 1'b0;
            rresp_reg <= AXI_OKAY;
            unique case (s_axi_araddr)
                SHUTDOWN_CONTROL_OFS: rdata_reg <= {24'h000000, ctrl_reg};
                DEADBAND_RESTART_OFS: rdata_reg <= {24'h000000, auto_restart_enable, deadband_reg};
                PWM_CONTROL_OFS: rdata_reg <= {30'h00000000, output_polarity_select};
                PIN_ENABLE_OFS: rdata_reg <= {28'h0000000, pin_enable_reg};
                INT_STATUS_OFS: rdata_reg <= {30'h00000000, status_reg};
                INT_MASK_OFS: rdata_reg <= {30'h00000000, mask_reg};
                default: begin
                    rdata_reg <= 32'h0000_0000;
                    rresp_reg <= AXI_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
            arready_reg <= 1'b1;
        end
    end

    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;

    // ---------------- configuration ----------------
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            auto_restart_enable <= DEADBAND_RESTART_RST[AUTO_RESTART_BIT];
            deadband_reg <= DEADBAND_RESTART_RST[6:0];
        end else if (wr_db) begin
            auto_restart_enable <= wdata_reg[AUTO_RESTART_BIT];
            deadband_reg <= wdata_reg[6:0];
        end
    end

    // polarity is taken at any time; changing it while driving is software's hazard
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            output_polarity_select <= POLARITY_RST;
        end else if (wr_pol) begin
            output_polarity_select <= wdata_reg[1:0];
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            pin_enable_reg <= PIN_ENABLE_RST;
        end else if (wr_pin) begin
            pin_enable_reg <= wdata_reg[3:0];
        end
    end

    // ---------------- shutdown control ----------------
    assign src_sel = ctrl_reg[SRC_SEL_LSB +: 3];
    // all sources are plain levels; a pulse shorter than a cycle may be missed
    assign cause = (src_sel[SRC_COMP1_BIT] && comparator_1)
        || (src_sel[SRC_COMP2_BIT] && comparator_2)
        || (src_sel[SRC_FAULT_BIT] && !fault_input_n);

    always_comb begin
        flag_next = ctrl_reg[EVENT_FLAG_BIT];
        if (wr_ctrl && !cause) begin
            flag_next = wdata_reg[EVENT_FLAG_BIT];
        end
        if (auto_restart_enable && cause_prev_reg && !cause) begin
            flag_next = 1'b0;
        end
        if (cause) begin
            flag_next = 1'b1;
        end
    end

    assign shut_next = flag_next || (shut_reg && !pwm_period_start);

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ctrl_reg <= SHUTDOWN_CONTROL_RST;
            cause_prev_reg <= 1'b0;
            shut_reg <= 1'b0;
        end else begin
            ctrl_reg[EVENT_FLAG_BIT] <= flag_next;
            if (wr_ctrl) begin
                ctrl_reg[6:0] <= wdata_reg[6:0];
            end
            cause_prev_reg <= cause;
            shut_reg <= shut_next;
        end
    end

    // ---------------- pin drivers ----------------
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_pin
            // pins 0 and 2 (a, c) form one pair, pins 1 and 3 (b, d) the other
            localparam bit IS_AC = (gi % 2) == 0;
            logic [1:0] safe;
            logic pol;
            assign safe = IS_AC ? ctrl_reg[SAFE_AC_LSB +: 2] : ctrl_reg[SAFE_BD_LSB +: 2];
            assign pol = IS_AC ? output_polarity_select[POL_AC_BIT]
                : output_polarity_select[POL_BD_BIT];
            always_ff @(posedge clock) begin
                if (!rst_n) begin
                    out_reg[gi] <= 1'b0;
                    oe_n_reg[gi] <= 1'b1;
                end else if (shut_reg) begin
                    out_reg[gi] <= safe == SAFE_HIGH;
                    oe_n_reg[gi] <= !pin_enable_reg[gi] || safe[1];
                end else begin
                    out_reg[gi] <= pwm_raw[gi] ^ pol;
                    oe_n_reg[gi] <= !pin_enable_reg[gi];
                end
            end
        end
    endgenerate

    assign output_a = out_reg[0];
    assign output_b = out_reg[1];
    assign output_c = out_reg[2];
    assign output_d = out_reg[3];
    assign output_oe_n = oe_n_reg;

    // ---------------- interrupts ----------------
    assign event_vec[IRQ_PERIOD_BIT] = pwm_period_start;
    assign event_vec[IRQ_SHUTDOWN_BIT] = flag_next && !ctrl_reg[EVENT_FLAG_BIT];

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            status_reg <= '0;
        end else begin
            status_reg <= (status_reg & ~(wr_stat ? wdata_reg[IRQ_W-1:0] : '0)) | event_vec;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            mask_reg <= '0;
        end else if (wr_mask) begin
            mask_reg <= wdata_reg[IRQ_W-1:0];
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= |(status_reg & mask_reg);
        end
    end
    assign irq = irq_reg;

    // ---------------- assertions ----------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    a_cause_sets_flag: assert property (cause |=> ctrl_reg[EVENT_FLAG_BIT])
        else $error("flag not set by active cause");
    a_cause_shuts: assert property (cause |=> shut_reg ##1 (oe_n_reg[0]
        || out_reg[0] == (ctrl_reg[SAFE_AC_LSB +: 2] == SAFE_HIGH)))
        else $error("shutdown not entered");
    a_hold_period: assert property (shut_reg && !pwm_period_start |=> shut_reg)
        else $error("shutdown left mid period");
    a_resume_boundary: assert property ($fell(shut_reg) |-> $past(pwm_period_start))
        else $error("resume outside period start");
    a_no_auto_clear: assert property (!auto_restart_enable && ctrl_reg[EVENT_FLAG_BIT]
        && !wr_ctrl |=> ctrl_reg[EVENT_FLAG_BIT])
        else $error("flag cleared without software");
    a_auto_clear: assert property (auto_restart_enable && cause_prev_reg && !cause
        |=> !ctrl_reg[EVENT_FLAG_BIT])
        else $error("auto restart did not clear flag");
    a_write_blocked: assert property (wr_ctrl && cause |=> ctrl_reg[EVENT_FLAG_BIT])
        else $error("flag written during active cause");
    a_force_shutdown: assert property (wr_ctrl && wdata_reg[EVENT_FLAG_BIT]
        |=> ctrl_reg[EVENT_FLAG_BIT] ##0 shut_reg)
        else $error("software force ignored");
    a_safe_low: assert property (shut_reg && ctrl_reg[3:2] == SAFE_LOW && pin_enable_reg[0]
        |=> !out_reg[0] && !oe_n_reg[0])
        else $error("a pin not driven low in shutdown");
    a_safe_tri: assert property (shut_reg && ctrl_reg[1] |=> oe_n_reg[1] && oe_n_reg[3])
        else $error("b/d pair not tri-stated");
    a_polarity: assert property (!shut_reg && pin_enable_reg[0]
        |=> out_reg[0] == ($past(pwm_raw[0]) ^ $past(output_polarity_select[POL_AC_BIT])))
        else $error("polarity wrong on pin a");
    a_period_flag: assert property (pwm_period_start |=> status_reg[IRQ_PERIOD_BIT])
        else $error("period flag not set");
    a_reset_tristate: assert property (disable iff (1'b0) !rst_n |=> oe_n_reg == 4'hF)
        else $error("pins driven after reset");

    c_auto_restart: cover property (auto_restart_enable && shut_reg ##[1:200] $fell(shut_reg));
    c_sw_restart: cover property (!auto_restart_enable && wr_ctrl && !wdata_reg[EVENT_FLAG_BIT]
        && ctrl_reg[EVENT_FLAG_BIT] && !cause);
    c_blocked_write: cover property (wr_ctrl && cause);
    c_irq: cover property (irq_reg);
endmodule // pwm_auto_shutdown_restart

// *** hw/pwm_shutdown_pkg.sv ***
package pwm_shutdown_pkg;
    localparam int ADDR_W = 8;
    // register byte addresses
    localparam logic [7:0] SHUTDOWN_CONTROL_OFS = 8'h00;
    localparam logic [7:0] DEADBAND_RESTART_OFS = 8'h04;
    localparam logic [7:0] PWM_CONTROL_OFS = 8'h08;
    localparam logic [7:0] PIN_ENABLE_OFS = 8'h0C;
    localparam logic [7:0] INT_STATUS_OFS = 8'h10;
    localparam logic [7:0] INT_MASK_OFS = 8'h14;
    // shutdown_control fields
    localparam int EVENT_FLAG_BIT = 7;
    localparam int SRC_SEL_LSB = 4;
    localparam int SAFE_AC_LSB = 2;
    localparam int SAFE_BD_LSB = 0;
    // deadband_restart_register fields
    localparam int AUTO_RESTART_BIT = 7;
    // pwm_control_register: polarity bit 1 for the a/c pair, bit 0 for the b/d pair
    localparam int POL_AC_BIT = 1;
    localparam int POL_BD_BIT = 0;
    // interrupt status / mask bits
    localparam int IRQ_PERIOD_BIT = 0;
    localparam int IRQ_SHUTDOWN_BIT = 1;
    localparam int IRQ_W = 2;
    // source select bits
    localparam int SRC_COMP1_BIT = 0;
    localparam int SRC_COMP2_BIT = 1;
    localparam int SRC_FAULT_BIT = 2;
    // safe-state codes
    localparam logic [1:0] SAFE_LOW = 2'h0;
    localparam logic [1:0] SAFE_HIGH = 2'h1;
    // reset values, then AXI response codes
    localparam logic [7:0] SHUTDOWN_CONTROL_RST = 8'h00;
    localparam logic [7:0] DEADBAND_RESTART_RST = 8'h00;
    localparam logic [1:0] POLARITY_RST = 2'h0;
    localparam logic [3:0] PIN_ENABLE_RST = 4'h0;
    localparam logic [1:0] AXI_OKAY = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;
endpackage
